// ===== src/intr_consts.svh
// register offsets, field positions, reset values and timing figures of the interrupt block
`ifndef INTR_CONSTS_SVH
`define INTR_CONSTS_SVH

// register offsets in data space
`define OPT_ADDR        8'hc8
`define POL_ADDR        8'hda

// reset values
`define OPT_RESET       8'h00
`define POL_RESET       4'h0
`define RDATA_IDLE      8'h00

// option register field positions
`define OPT_LEVEL_BIT   6
`define OPT_EDGE2_BIT   5
`define OPT_GEN_BIT     4

// polarity register field positions
`define POL_D_BIT       3
`define POL_C_BIT       2
`define POL_A_BIT       1
`define POL_B_BIT       0

// vector source numbers
`define SRC_NMI         3'h0
`define SRC_ONE         3'h1
`define SRC_TWO         3'h2
`define SRC_THREE       3'h3
`define SRC_FOUR        3'h4

// timing
`define CLK_PERIOD_NS   100
`define STAB_TIME_US    2000

`endif

// ===== src/intr_pkg.sv
// types shared by the interrupt option and wake control block
package intr_pkg;

  typedef enum logic [3:0] {
    PS_RUN  = 4'b0001,
    PS_WAIT = 4'b0010,
    PS_STOP = 4'b0100,
    PS_STAB = 4'b1000
  } pstate_t;

  typedef enum logic [2:0] {
    MD_NORMAL = 3'b001,
    MD_INTR   = 3'b010,
    MD_NMI    = 3'b100
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bitOp;
  } reg_bus_t;

  typedef struct packed {
    logic       waitExec;
    logic       stopExec;
    logic       vecAck;
    logic [2:0] ackSrc;
    logic       reti;
  } core_cmd_t;

  typedef struct packed {
    logic timerZeroFlag;
    logic timerIrqMask;
    logic convDoneFlag;
    logic converterIrqMask;
    logic byteReceivedFlag;
    logic serialRxIrqMask;
    logic byteSentFlag;
    logic serialTxIrqMask;
  } src4_req_t;

  typedef struct packed {
    logic reloadOverflowFlag;
    logic reloadOverflowMask;
    logic compareMatchFlag;
    logic reloadCompareMask;
    logic inputEdgeFlag;
    logic reloadEdgeMask;
  } src3_req_t;

  typedef struct packed {
    logic       irqReq;
    logic [2:0] irqVec;
  } core_irq_t;

endpackage

// ===== src/pin_event_detect.sv
// synchronises one port's pins and reports active edges and active levels
`timescale 1ns/1ps
module pin_event_detect #(
  parameter int PW = 8
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // pins and per-pin interrupt enable
  input  wire logic [PW-1:0] pins,
  input  wire logic [PW-1:0] armed,
  // 1 selects rising edge or high level
  input  wire logic          senseHigh,
  // results
  output logic               edgeHit,
  output logic               levelHit
);

  typedef struct packed {
    logic [PW-1:0] meta;
    logic [PW-1:0] sync;
    logic [PW-1:0] prev;
  } det_state_t;

  det_state_t st;
  det_state_t next_st;

  initial begin
    if (PW < 1 || PW > 8) $error("pin_event_detect: PW must be 1 to 8");
  end

  always_comb begin
    next_st      = st;
    next_st.meta = pins;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // pulled-up idle level, so no false edge follows reset
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  // active sense follows the polarity input
  assign edgeHit  = |(armed & (senseHigh ? (st.sync & ~st.prev) : (~st.sync & st.prev)));
  assign levelHit = |(armed & (senseHigh ? st.sync : ~st.sync));

endmodule

// ===== src/interrupt_option_and_wake_control.sv
// interrupt request logic with option and polarity registers and WAIT/STOP control
//
// Notes on behaviour
// - option register at c8h, write-only, no single-bit writes, resets to 00h
// - option bit 6 set makes port A on source 1 level sensitive, clear makes it edge; serial end is always level
// - option bit 5 picks the edge polarity of source 2
// - option bit 4 enables all sources; cleared, only the non-maskable one stays
// - with global enable low the non-maskable source is served but cannot wake
// - timer, converter, serial receive and transmit events, each masked, request source 4
// - reload timer overflow, compare and input edge, each masked, share source 3
// - port C to source 0; port A and serial end to source 1; B and D to 2
// - polarity register at dah, read/write, bits D C A B, set inverts, reset clears
// - ports B and D fall when polarity equals source-2 bit, otherwise rise
// - port A falling, low, rising or high from level bit and its polarity bit
// - port C always edge: falling with polarity zero, rising with one
// - WAIT stops fetching while oscillator and peripherals keep running
// - interrupt leaves WAIT with no added delay
// - pin or watchdog reset ends WAIT or STOP through normal reset
// - STOP only with watchdog off; oscillator halts until interrupt or reset
// - interrupt leaving STOP inserts a stabilisation delay before fetching
// - waking by interrupt leaves the oscillator selection as it was
// - from main program the waking routine runs first, then the next instruction
// - from non-maskable routine any request wakes; stays in that mode, others pend
// - edge source keeps one latched request, set by edge, cleared at routine start
// - fixed priority: source 0 preempts all, sources 1 to 4 in order, no nesting
// - WAIT and STOP are ignored while an enabled request is pending
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "intr_consts.svh"
module interrupt_option_and_wake_control #(
  parameter int PW       = 8,
  parameter int STAB_US  = `STAB_TIME_US,
  parameter int CNT_W    = 16
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // register port
  input  wire intr_pkg::reg_bus_t  regBus,
  output logic [7:0]               rdata,
  // core commands and status
  input  wire intr_pkg::core_cmd_t coreCmd,
  input  wire logic                watchdogActive,
  // peripheral requests
  input  wire intr_pkg::src4_req_t src4Req,
  input  wire intr_pkg::src3_req_t src3Req,
  input  wire logic                spiDone,
  // port pins and per-pin interrupt enables
  input  wire logic [PW-1:0]       pinsA,
  input  wire logic [PW-1:0]       pinsB,
  input  wire logic [PW-1:0]       pinsC,
  input  wire logic [PW-1:0]       pinsD,
  input  wire logic [PW-1:0]       irqEnA,
  input  wire logic [PW-1:0]       irqEnB,
  input  wire logic [PW-1:0]       irqEnC,
  input  wire logic [PW-1:0]       irqEnD,
  // core control
  output intr_pkg::core_irq_t      irq,
  output logic                     coreFetch,
  output logic                     oscRun,
  output logic                     stabBusy
);
  import intr_pkg::*;

  localparam int STAB_CYCLES = (STAB_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  initial begin
    if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << CNT_W)) $error("stabilisation count does not fit CNT_W");
  end

  typedef struct packed {
    logic             optLevel;
    logic             optEdge2;
    logic             optGen;
    logic [3:0]       polarity;
    logic             latch0;
    logic             latch1;
    logic             latch2;
    mode_t            mode;
    mode_t            prevMode;
    pstate_t          pstate;
    logic [CNT_W-1:0] stabCnt;
    logic [7:0]       rdata;
    core_irq_t        irq;
    logic             coreFetch;
    logic             oscRun;
    logic             stabBusy;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic       edgeA;
  logic       lvlA;
  logic       edgeB;
  logic       edgeC;
  logic       edgeD;
  logic       senseB;
  logic       senseD;
  logic       gen;
  logic       set0;
  logic       set1;
  logic       set2;
  logic       raw3;
  logic       raw4;
  logic       src1Level;
  logic [4:0] pend;
  logic [4:0] svc;
  logic       wake;
  logic       ack0;
  logic       ack1;
  logic       ack2;

  assign gen    = st.optGen;
  assign senseB = st.polarity[`POL_B_BIT] ^ st.optEdge2;
  assign senseD = st.polarity[`POL_D_BIT] ^ st.optEdge2;

  pin_event_detect #(.PW(PW)) u_portA (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pins      (pinsA),
    .armed     (irqEnA),
    .senseHigh (st.polarity[`POL_A_BIT]),
    .edgeHit   (edgeA),
    .levelHit  (lvlA)
  );

  pin_event_detect #(.PW(PW)) u_portB (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pins      (pinsB),
    .armed     (irqEnB),
    .senseHigh (senseB),
    .edgeHit   (edgeB),
    .levelHit  ()
  );

  pin_event_detect #(.PW(PW)) u_portC (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pins      (pinsC),
    .armed     (irqEnC),
    .senseHigh (st.polarity[`POL_C_BIT]),
    .edgeHit   (edgeC),
    .levelHit  ()
  );

  pin_event_detect #(.PW(PW)) u_portD (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pins      (pinsD),
    .armed     (irqEnD),
    .senseHigh (senseD),
    .edgeHit   (edgeD),
    .levelHit  ()
  );

  // request sources
  always_comb begin
    raw4 = gen & ((src4Req.timerZeroFlag & src4Req.timerIrqMask)
                | (src4Req.convDoneFlag & src4Req.converterIrqMask)
                | (src4Req.byteReceivedFlag & src4Req.serialRxIrqMask)
                | (src4Req.byteSentFlag & src4Req.serialTxIrqMask));
    raw3 = gen & ((src3Req.reloadOverflowFlag & src3Req.reloadOverflowMask)
                | (src3Req.compareMatchFlag & src3Req.reloadCompareMask)
                | (src3Req.inputEdgeFlag & src3Req.reloadEdgeMask));
    src1Level = gen & ((st.optLevel & lvlA) | spiDone);
    set0 = edgeC;
    set1 = gen & ~st.optLevel & edgeA;
    set2 = gen & (edgeB | edgeD);
    pend[0] = st.latch0;
    pend[1] = (st.latch1 & gen) | src1Level;
    pend[2] = st.latch2 & gen;
    pend[3] = raw3;
    pend[4] = raw4;
    wake = gen & (|pend);
    case (st.mode)
      MD_NMI:  svc = 5'h00;
      MD_INTR: svc = {4'h0, pend[0]};
      default: svc = pend;
    endcase
    ack0 = coreCmd.vecAck & (coreCmd.ackSrc == `SRC_NMI);
    ack1 = coreCmd.vecAck & (coreCmd.ackSrc == `SRC_ONE);
    ack2 = coreCmd.vecAck & (coreCmd.ackSrc == `SRC_TWO);
  end

  always_comb begin
    next_st = st;
    // edge latches hold one request; a new edge wins over the clearing acknowledge
    next_st.latch0 = set0 | (st.latch0 & ~ack0);
    next_st.latch1 = set1 | (st.latch1 & ~ack1);
    next_st.latch2 = set2 | (st.latch2 & ~ack2);
    // register writes
    if (regBus.wr && regBus.addr == `OPT_ADDR && !regBus.bitOp) begin
      next_st.optLevel = regBus.wdata[`OPT_LEVEL_BIT];
      next_st.optEdge2 = regBus.wdata[`OPT_EDGE2_BIT];
      next_st.optGen   = regBus.wdata[`OPT_GEN_BIT];
    end
    if (regBus.wr && regBus.addr == `POL_ADDR) begin
      next_st.polarity = regBus.wdata[3:0];
    end
    // read data stand one cycle; option register reads as zero
    next_st.rdata = `RDATA_IDLE;
    if (regBus.rd && regBus.addr == `POL_ADDR) begin
      next_st.rdata = {4'h0, st.polarity};
    end
    // core mode tracking
    if (coreCmd.vecAck) begin
      if (coreCmd.ackSrc == `SRC_NMI) begin
        next_st.mode     = MD_NMI;
        next_st.prevMode = st.mode;
      end else begin
        next_st.mode = MD_INTR;
      end
    end else if (coreCmd.reti) begin
      next_st.mode = (st.mode == MD_NMI) ? st.prevMode : MD_NORMAL;
    end
    // power state
    case (st.pstate)
      PS_RUN: begin
        if ((coreCmd.waitExec || coreCmd.stopExec) && !wake) begin
          next_st.coreFetch = 1'b0;
          if (coreCmd.stopExec && !watchdogActive) begin
            next_st.pstate = PS_STOP;
            next_st.oscRun = 1'b0;
          end else begin
            next_st.pstate = PS_WAIT;
          end
        end
      end
      PS_WAIT: begin
        if (wake) begin
          next_st.pstate    = PS_RUN;
          next_st.coreFetch = 1'b1;
        end
      end
      PS_STOP: begin
        if (wake) begin
          next_st.pstate  = PS_STAB;
          next_st.oscRun  = 1'b1;
          next_st.stabCnt = CNT_W'(STAB_CYCLES - 1);
        end
      end
      PS_STAB: begin
        if (st.stabCnt == '0) begin
          next_st.pstate    = PS_RUN;
          next_st.coreFetch = 1'b1;
        end else begin
          next_st.stabCnt = st.stabCnt - 1'b1;
        end
      end
      default: begin
        next_st.pstate    = PS_RUN;
        next_st.coreFetch = 1'b1;
        next_st.oscRun    = 1'b1;
      end
    endcase
    // highest priority serviceable request, offered only while running
    next_st.irq.irqReq = (st.pstate == PS_RUN) && (|svc) && !coreCmd.vecAck;
    if (svc[0]) begin
      next_st.irq.irqVec = `SRC_NMI;
    end else if (svc[1]) begin
      next_st.irq.irqVec = `SRC_ONE;
    end else if (svc[2]) begin
      next_st.irq.irqVec = `SRC_TWO;
    end else if (svc[3]) begin
      next_st.irq.irqVec = `SRC_THREE;
    end else begin
      next_st.irq.irqVec = `SRC_FOUR;
    end
    // stabilisation flag kept in a flop so the output is registered
    next_st.stabBusy = (next_st.pstate == PS_STAB);
  end

  // reset returns everything to run through the normal path
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st           <= '0;
      st.mode      <= MD_NORMAL;
      st.prevMode  <= MD_NORMAL;
      st.pstate    <= PS_RUN;
      st.polarity  <= `POL_RESET;
      st.optLevel  <= 1'b0;
      st.optEdge2  <= 1'b0;
      st.optGen    <= 1'b0;
      st.coreFetch <= 1'b1;
      st.oscRun    <= 1'b1;
      st.rdata     <= `RDATA_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata         = st.rdata;
  assign irq           = st.irq;
  assign coreFetch     = st.coreFetch;
  assign oscRun        = st.oscRun;
  assign stabBusy      = st.stabBusy;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_wait_no_fetch: assert property (st.pstate == PS_WAIT |-> !coreFetch && oscRun)
    else $error("fetch or oscillator wrong in wait");
  a_wait_wake_fast: assert property (st.pstate == PS_WAIT && wake |=> coreFetch)
    else $error("wait exit not immediate");
  a_stop_osc_off: assert property (st.pstate == PS_STOP |-> !oscRun && !coreFetch)
    else $error("oscillator running in stop");
  a_stop_wdog_off: assert property (st.pstate == PS_RUN && coreCmd.stopExec && watchdogActive |=> st.pstate != PS_STOP)
    else $error("stop entered with watchdog on");
  a_stab_delay_held: assert property (st.pstate == PS_STOP && wake |=> (!coreFetch && oscRun) [*8])
    else $error("no stabilisation delay after stop");
  a_gen_low_nowake: assert property (st.pstate == PS_WAIT && !gen |=> st.pstate == PS_WAIT)
    else $error("woke with global enable low");
  a_nmi_top_prio: assert property (st.pstate == PS_RUN && st.latch0 && st.mode != MD_NMI && !coreCmd.vecAck
                                   |=> irq.irqReq && irq.irqVec == `SRC_NMI)
    else $error("nmi not offered first");
  a_gen_masks_all: assert property (st.pstate == PS_RUN && !gen && !st.latch0 |=> !irq.irqReq)
    else $error("maskable request with global enable low");
  a_enter_blocked: assert property (st.pstate == PS_RUN && coreCmd.waitExec && wake |=> st.pstate == PS_RUN)
    else $error("wait taken with request pending");
  a_opt_bitop_ign: assert property (regBus.wr && regBus.addr == `OPT_ADDR && regBus.bitOp
                                    |=> $stable({st.optLevel, st.optEdge2, st.optGen}))
    else $error("single-bit write changed option register");
  a_pol_readback: assert property (regBus.rd && regBus.addr == `POL_ADDR |=> rdata == {4'h0, $past(st.polarity)})
    else $error("polarity readback wrong");
  a_latch_cleared: assert property (ack1 && !set1 |=> !st.latch1)
    else $error("edge latch not cleared at routine start");
  a_latch_set_edge: assert property (set2 |=> st.latch2)
    else $error("edge latch not set by active edge");
  a_stop_wake_stab: assert property (st.pstate == PS_STOP && wake |=> stabBusy && oscRun)
    else $error("stop exit without stabilisation");
  a_nmi_mode_kept: assert property (st.mode == MD_NMI && !coreCmd.reti |=> st.mode == MD_NMI)
    else $error("left non-maskable mode without return");

  c_wait_wake: cover property (st.pstate == PS_WAIT ##1 st.pstate == PS_RUN);
  c_stop_stab: cover property (st.pstate == PS_STAB && st.stabCnt == '0 ##1 coreFetch);
  c_nmi_ack: cover property (irq.irqReq && irq.irqVec == `SRC_NMI ##1 ack0);
  c_level_src1: cover property (st.optLevel && src1Level ##1 irq.irqReq);
  c_pend_blocked: cover property (st.pstate == PS_RUN && coreCmd.waitExec && wake);

endmodule

// ===== dv/core_model.sv
// processor core stand-in: acknowledges requests, returns from routines, issues WAIT and STOP
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // block side
  input  wire intr_pkg::core_irq_t irq,
  input  wire logic                coreFetch,
  output intr_pkg::core_cmd_t      coreCmd,
  // bench side
  input  wire logic [3:0]          ackDelay,
  input  wire logic [1:0]          sleepCmd,
  output logic [7:0]               ackCount,
  output logic [2:0]               lastVec
);
  import intr_pkg::*;
  logic [3:0] waitCnt;
  logic [3:0] retiCnt;
  logic       inRoutine;
  logic       ackNow;
  logic       retiNow;

  assign coreCmd.waitExec = sleepCmd[0];
  assign coreCmd.stopExec = sleepCmd[1];
  assign coreCmd.vecAck   = ackNow;
  assign coreCmd.ackSrc   = lastVec;
  assign coreCmd.reti     = retiNow;

  // only a fetching core takes a vector; routines last a fixed while, then return
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitCnt   <= 4'h0;
      retiCnt   <= 4'h0;
      inRoutine <= 1'b0;
      ackNow    <= 1'b0;
      retiNow   <= 1'b0;
      ackCount  <= 8'h00;
      lastVec   <= 3'h0;
    end else begin
      ackNow  <= 1'b0;
      retiNow <= 1'b0;
      if (inRoutine) begin
        retiCnt <= retiCnt + 4'h1;
        if (retiCnt == 4'h8) begin
          retiNow   <= 1'b1;
          inRoutine <= 1'b0;
        end
      end else if (irq.irqReq && coreFetch && !ackNow) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt >= ackDelay) begin
          ackNow    <= 1'b1;
          lastVec   <= irq.irqVec;
          ackCount  <= ackCount + 8'h01;
          inRoutine <= 1'b1;
          retiCnt   <= 4'h0;
          waitCnt   <= 4'h0;
        end
      end else begin
        waitCnt <= 4'h0;
      end
    end
  end
endmodule

// ===== dv/interrupt_option_and_wake_control_bench.sv
// self-checking bench for the interrupt option and wake control block
`timescale 1ns/1ps
`include "intr_consts.svh"
module interrupt_option_and_wake_control_bench;
  import intr_pkg::*;
  localparam int STAB = 2;
  logic       clk_sys;
  logic       resetn;
  reg_bus_t   regBus;
  logic [7:0] rdata;
  core_cmd_t  coreCmd;
  logic       watchdogActive;
  src4_req_t  src4Req;
  src3_req_t  src3Req;
  logic       spiDone;
  logic [7:0] pinArr [4];
  logic [7:0] irqEn;
  core_irq_t  irq;
  logic       coreFetch;
  logic       oscRun;
  logic       stabBusy;
  logic [3:0] ackDelay;
  logic [1:0] sleepCmd;
  logic [7:0] ackCount;
  logic [2:0] lastVec;
  int         n_errors;
  int         compares;
  int         cycles = 0;
  int         n;

  interrupt_option_and_wake_control #(.PW(8), .STAB_US(STAB)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .regBus(regBus), .rdata(rdata),
    .coreCmd(coreCmd), .watchdogActive(watchdogActive), .src4Req(src4Req), .src3Req(src3Req),
    .spiDone(spiDone), .pinsA(pinArr[0]), .pinsB(pinArr[1]), .pinsC(pinArr[2]), .pinsD(pinArr[3]),
    .irqEnA(irqEn), .irqEnB(irqEn), .irqEnC(irqEn), .irqEnD(irqEn),
    .irq(irq), .coreFetch(coreFetch), .oscRun(oscRun), .stabBusy(stabBusy)
  );

  core_model core (
    .clk_sys(clk_sys), .resetn(resetn), .irq(irq), .coreFetch(coreFetch), .coreCmd(coreCmd),
    .ackDelay(ackDelay), .sleepCmd(sleepCmd), .ackCount(ackCount), .lastVec(lastVec)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bop = 1'b0);
    @(posedge clk_sys);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bitOp: bop};
    @(posedge clk_sys);
    regBus.wr    <= 1'b0;
    regBus.bitOp <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bitOp: 1'b0};
    @(posedge clk_sys);
    regBus.rd <= 1'b0;
    #1 check(nm, rdata, exp);
  endtask

  task automatic sleep(input logic [1:0] c);
    @(posedge clk_sys);
    sleepCmd <= c;
    @(posedge clk_sys);
    sleepCmd <= 2'b00;
  endtask

  // waits for the core to take a vector and compares it; ff means none was taken
  task automatic expIrq(input logic [2:0] v);
    logic [7:0] c0;
    c0 = ackCount;
    for (int i = 0; i < 40 && ackCount == c0; i++) @(posedge clk_sys);
    check("ack vector", (ackCount == c0) ? 8'hff : {5'h00, lastVec}, {5'h00, v});
  endtask

  task automatic expNone();
    logic [7:0] c0;
    c0 = ackCount;
    tick(14);
    check("no ack", ackCount - c0, 8'h00);
  endtask

  // settle the start level with maskable sources off, then drive the active change and undo it
  task automatic pinCase(input int p, input logic fall, input logic [2:0] v, input logic [7:0] opt,
                         input logic [3:0] pol);
    wr(`OPT_ADDR, opt);
    wr(`POL_ADDR, {4'h0, pol});
    pinArr[p] <= fall ? 8'hff : 8'h00;
    tick(6);
    wr(`OPT_ADDR, opt | 8'h10);
    pinArr[p] <= fall ? 8'h00 : 8'hff;
    expIrq(v);
    pinArr[p] <= fall ? 8'hff : 8'h00;
    expNone();
  endtask

  task automatic endTest(input string nm);
    $display("test %s finished", nm);
  endtask

  initial begin
    resetn         = 1'b0;
    regBus         = '0;
    watchdogActive = 1'b0;
    src4Req        = '0;
    src3Req        = '0;
    spiDone        = 1'b0;
    pinArr         = '{8'hff, 8'hff, 8'hff, 8'hff};
    irqEn          = 8'hff;
    ackDelay       = 4'h0;
    sleepCmd       = 2'b00;
    n_errors       = 0;
    compares       = 0;
    tick(10);
    resetn <= 1'b1;
    rd(`OPT_ADDR, 8'h00, "option reset");
    rd(`POL_ADDR, 8'h00, "polarity reset");
    wr(`POL_ADDR, 8'hff);
    rd(`POL_ADDR, 8'h0f, "polarity");
    rd(8'h55, 8'h00, "unmapped");
    wr(`OPT_ADDR, 8'h70);
    rd(`OPT_ADDR, 8'h00, "option write-only");
    wr(`POL_ADDR, 8'h00);
    wr(`OPT_ADDR, 8'h00);
    endTest("registers");
    src4Req <= 8'hc0;
    wr(`OPT_ADDR, 8'h8f);
    expNone();
    wr(`OPT_ADDR, 8'h10, 1'b1);
    expNone();
    wr(`OPT_ADDR, 8'h10);
    expIrq(3'h4);
    src4Req <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      src4Req <= 8'h80 >> (2 * i);
      expNone();
      src4Req <= 8'hc0 >> (2 * i);
      expIrq(3'h4);
      src4Req <= 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      src3Req <= 6'h20 >> (2 * i);
      expNone();
      src3Req <= 6'h30 >> (2 * i);
      expIrq(3'h3);
      src3Req <= 6'h00;
    end
    spiDone <= 1'b1;
    expIrq(3'h1);
    spiDone  <= 1'b0;
    src3Req  <= 6'h30;
    src4Req  <= 8'hc0;
    ackDelay <= 4'h3;
    expIrq(3'h3);
    src3Req <= 6'h00;
    expIrq(3'h4);
    src4Req  <= 8'h00;
    ackDelay <= 4'h0;
    wr(`OPT_ADDR, 8'h00);
    src4Req <= 8'hc0;
    expNone();
    src4Req <= 8'h00;
    endTest("sources");
    pinCase(2, 1'b1, 3'h0, 8'h00, 4'h0);
    wr(`OPT_ADDR, 8'h00);
    pinArr[2] <= 8'h00;
    expIrq(3'h0);
    pinArr[2] <= 8'hff;
    expNone();
    pinCase(2, 1'b0, 3'h0, 8'h00, 4'h4);
    for (int k = 0; k < 4; k++) begin
      pinCase(0, !k[0], 3'h1, {1'b0, k[1], 6'h00}, {2'b00, k[0], 1'b0});
    end
    for (int k = 0; k < 8; k++) begin
      pinCase(1, k[1] == k[0], 3'h2, {2'b00, k[0], 5'h00}, {k[2], 2'b00, k[1]});
      pinCase(3, k[2] == k[0], 3'h2, {2'b00, k[0], 5'h00}, {k[2], 2'b00, k[1]});
    end
    endTest("pins");
    wr(`POL_ADDR, 8'h00);
    pinArr[2] <= 8'hff;
    tick(6);
    wr(`OPT_ADDR, 8'h10);
    sleep(2'b01);
    tick(2);
    check("wait fetch", 8'(coreFetch), 8'h00);
    check("wait osc", 8'(oscRun), 8'h01);
    src4Req <= 8'hc0;
    tick(3);
    check("wait wake", 8'(coreFetch), 8'h01);
    check("wait stab", 8'(stabBusy), 8'h00);
    expIrq(3'h4);
    src4Req  <= 8'h00;
    ackDelay <= 4'hf;
    tick(12);
    src4Req <= 8'hc0;
    tick(2);
    sleep(2'b01);
    tick(3);
    check("pending wait", 8'(coreFetch), 8'h01);
    ackDelay <= 4'h0;
    expIrq(3'h4);
    src4Req <= 8'h00;
    tick(12);
    sleep(2'b10);
    tick(2);
    check("stop osc", 8'(oscRun), 8'h00);
    check("stop fetch", 8'(coreFetch), 8'h00);
    pinArr[2] <= 8'h00;
    n = 0;
    for (int i = 0; i < 20 && stabBusy !== 1'b1; i++) @(posedge clk_sys);
    while (stabBusy === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    check("stab cycles", 8'(n), 8'((STAB * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS));
    check("stab osc", 8'(oscRun), 8'h01);
    expIrq(3'h0);
    pinArr[2]      <= 8'hff;
    watchdogActive <= 1'b1;
    tick(12);
    sleep(2'b10);
    tick(2);
    check("watchdog osc", 8'(oscRun), 8'h01);
    check("watchdog fetch", 8'(coreFetch), 8'h00);
    src4Req <= 8'hc0;
    expIrq(3'h4);
    src4Req        <= 8'h00;
    watchdogActive <= 1'b0;
    tick(12);
    wr(`OPT_ADDR, 8'h00);
    sleep(2'b10);
    tick(2);
    pinArr[2] <= 8'h00;
    tick(12);
    check("masked wake", 8'(coreFetch), 8'h00);
    check("masked osc", 8'(oscRun), 8'h00);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    #1 check("reset fetch", 8'(coreFetch), 8'h01);
    check("reset osc", 8'(oscRun), 8'h01);
    endTest("power");
    stop_test();
  end
endmodule
